// file: csp_pkg.sv
// Purpose: shared constants and types of the serial program port
// Assumes: 25 MHz system clock, standard-mode two-wire bus
// Notes: byte indices are 6 bits wide to match the transfer counters
package csp_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int BUS_MAX_HZ = 100_000;
  // least quarter of a bus bit, rounded up
  localparam int QTR_CYCLES_DEF = (CLK_HZ + 4 * BUS_MAX_HZ - 1) /
                                  (4 * BUS_MAX_HZ);
  localparam int PD_MAX_NS = 3_000_000;
  localparam int PD_MAX_CYCLES = PD_MAX_NS / CLK_PERIOD_NS;
  localparam int WDOG_TICK_NS = 1_000_000_000;
  localparam int WDOG_TICK_CYCLES_DEF = WDOG_TICK_NS / CLK_PERIOD_NS;

  localparam logic [7:0] ADDR_WR = 8'hd2;
  localparam logic [7:0] ADDR_RD = 8'hd3;
  localparam int NUM_BYTES = 29;
  localparam int FS_W = 5;
  localparam int OEN_W = 40;
  localparam logic [5:0] LAST_IDX = 6'h1c;
  localparam logic [5:0] IDX_CFG = 6'h00;
  localparam logic [5:0] IDX_OUT1 = 6'h01;
  localparam logic [5:0] IDX_COUNT = 6'h06;
  localparam logic [5:0] IDX_LATCH = 6'h07;
  localparam logic [5:0] IDX_WDOG = 6'h08;
  localparam logic [5:0] IDX_WSEC = 6'h09;
  localparam logic [5:0] IDX_VENDOR = 6'h0b;
  localparam logic [5:0] IDX_REV = 6'h0c;
  localparam logic [5:0] GRP_BASE = 6'h0e;
  localparam int GRP_N = 7;
  localparam int CFG_HWSEL_BIT = 3;
  localparam int WDOG_EN_BIT = 5;
  localparam int WDOG_FIRED_BIT = 6;
  localparam int MEM_EN_BIT = 0;
  // bytes 28 down to 0
  localparam logic [NUM_BYTES*8-1:0] REG_RST = {{19{8'h00}}, 8'hff, 8'h00,
    8'h00, 8'h06, 8'hff, 8'heb, 8'hff, 8'hff, 8'h1f, 8'h02};

  // host register map
  localparam logic [11:0] H_CTRL = 12'h000;
  localparam logic [11:0] H_LEN = 12'h004;
  localparam logic [11:0] H_STAT = 12'h008;
  localparam logic [11:0] H_BUF = 12'h100;

  typedef enum logic [6:0] {
    DS_IDLE = 7'b0000001, DS_ADDR = 7'b0000010, DS_RX = 7'b0000100,
    DS_ACK = 7'b0001000, DS_TX = 7'b0010000, DS_RACK = 7'b0100000,
    DS_SKIP = 7'b1000000
  } csp_dev_st_t;

  typedef enum logic [3:0] {
    HS_IDLE = 4'b0001, HS_START = 4'b0010, HS_BIT = 4'b0100,
    HS_STOP = 4'b1000
  } csp_host_st_t;
endpackage

// file: csp_if.sv
// Purpose: two-wire link between host end and device end
// Assumes: open-drain wires with pull-ups
// Notes: a wire is low when any party enables a low drive
`timescale 1ns/10ps
interface csp_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  assign scl = !(host_scl_oe && !host_scl_o);
  assign sda = !(host_sda_oe && !host_sda_o) && !(dev_sda_oe && !dev_sda_o);
  modport host(output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe,
               input scl, sda);
  modport dev(output dev_sda_o, dev_sda_oe, input scl, sda);
endinterface

// file: csp_sync.sv
// Purpose: two-flop synchroniser for levels from outside the clock
// Assumes: one clock, asynchronous active-low reset
// Notes: only the second stage may be read
`timescale 1ns/10ps
module csp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RST;
      q <= RST;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// file: csp_dev.sv
// Purpose: device end of the clock generator serial program port
// Assumes: host keeps standard-mode timing; scl only sampled
// Notes: Function
// Function
// - host starts, sends write address d2
// - host sends ignored command byte, acked
// - host sends ignored count byte, acked
// - host writes bytes upward from 0 to 28
// - device acks every written byte
// - host ends write with stop
// - host starts, sends read address d3
// - device returns count byte first
// - default read returns bytes 0 to 6
// - read returns bytes 0 to count value
// - host acks each read byte, then stops
// - frequency straps latched once after reset
// - host-bus frequency follows latched straps while byte 0 bit 3 is clear
// - power-down input stops clocks within 3ms
// - memory clock disabled by register write
// - watchdog restores safe frequency on timeout
// - byte 6 sets read count, reset 06
// - ignore command/count, load until stop
// - grouped bytes load only when complete
// - host bus rate at most 100 kbit/s
`timescale 1ns/10ps
module csp_dev #(
  parameter int unsigned WDOG_TICK_CYCLES = csp_pkg::WDOG_TICK_CYCLES_DEF,
  parameter logic [7:0] VENDOR_BYTE = 8'h5a, // arbitrary value
  parameter logic [7:0] REVISION_BYTE = 8'ha5 // arbitrary value
) (
  input wire logic hclk,
  input wire logic hresetn,
  csp_if.dev link,
  input wire logic freq_select_in0,
  input wire logic freq_select_in1,
  input wire logic freq_select_in2,
  input wire logic freq_select_in3,
  input wire logic freq_select_in4,
  input wire logic power_down_n,
  input wire logic usb_rate_sel_n,
  input wire logic wdog_kick,
  output logic [csp_pkg::FS_W-1:0] host_bus_freq_sel,
  output logic selectable_usb_rate_48,
  output logic mem_clk_en,
  output logic [csp_pkg::OEN_W-1:0] output_enable,
  output logic clocks_run,
  output logic wdog_fired
);
  import csp_pkg::*;

  typedef struct packed {
    csp_dev_st_t st;
    logic [3:0] bitcnt;
    logic [7:0] sh;
    logic [7:0] txb;
    logic rd;
    logic [5:0] phase;
    logic scl_q;
    logic sda_q;
    logic sda_oe;
    logic [NUM_BYTES-1:0][7:0] regs;
    logic [GRP_N-1:0] gmask;
    logic [GRP_N-1:0][7:0] gshadow;
    logic [FS_W-1:0] latched;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic [31:0] tick;
    logic [7:0] secs;
    logic fired;
    logic [FS_W-1:0] freq_out;
    logic usb48;
    logic mem_en;
    logic [OEN_W-1:0] oen;
    logic run;
  } csp_dev_s_t;

  csp_dev_s_t r;
  csp_dev_s_t n;
  logic [8:0] sy;

  csp_sync #(.W(9), .RST(9'h1ff)) u_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .d({link.scl, link.sda, power_down_n, usb_rate_sel_n, freq_select_in4,
        freq_select_in3, freq_select_in2, freq_select_in1, freq_select_in0}),
    .q(sy)
  );

  function automatic logic [7:0] rd_byte(csp_dev_s_t s, logic [5:0] i);
    logic [7:0] b;
    b = 8'hff;
    if (i == IDX_LATCH) begin
      b = {3'h0, ~s.latched};
    end else if (i == IDX_VENDOR) begin
      b = VENDOR_BYTE;
    end else if (i == IDX_REV) begin
      b = REVISION_BYTE;
    end else if (i == IDX_WDOG) begin
      b = s.regs[IDX_WDOG[4:0]];
      b[WDOG_FIRED_BIT] = s.fired;
    end else if (i <= LAST_IDX) begin
      b = s.regs[i[4:0]];
    end
    return b;
  endfunction

  function automatic logic grp_done(logic [GRP_N-1:0] m, int k);
    logic d;
    d = (k < 2) ? &m[1:0] : ((k < 4) ? &m[3:2] : &m[6:4]);
    return d;
  endfunction

  always_comb begin
    logic scl_s;
    logic sda_s;
    logic rise;
    logic fall;
    logic start_c;
    logic stop_c;
    logic [5:0] idx;
    logic [5:0] gi;
    logic [7:0] nb;
    logic [7:0] cnt;
    n = r;
    nb = 8'hff;
    scl_s = sy[8];
    sda_s = sy[7];
    rise = scl_s && !r.scl_q;
    fall = !scl_s && r.scl_q;
    start_c = scl_s && r.scl_q && r.sda_q && !sda_s;
    stop_c = scl_s && r.scl_q && !r.sda_q && sda_s;
    idx = r.phase - 6'h02;
    gi = idx - GRP_BASE;
    cnt = r.regs[IDX_COUNT[4:0]];
    n.scl_q = scl_s;
    n.sda_q = sda_s;
    // count byte first, then bytes 0..count, then released bus
    if (r.phase == 6'h00) begin
      nb = cnt;
    end else if ({2'b00, r.phase - 6'h01} <= cnt) begin
      nb = rd_byte(r, r.phase - 6'h01);
    end else begin
      nb = 8'hff;
    end
    case (r.st)
      DS_IDLE, DS_SKIP: begin
      end
      DS_ADDR, DS_RX: begin
        if (rise) begin
          n.sh = {r.sh[6:0], sda_s};
          n.bitcnt = r.bitcnt + 4'h1;
        end else if (fall && r.bitcnt == 4'h8) begin
          n.bitcnt = 4'h0;
          if (r.st == DS_ADDR) begin
            if (r.sh == ADDR_WR || r.sh == ADDR_RD) begin
              n.rd = (r.sh == ADDR_RD);
              n.sda_oe = 1'b1;
              n.st = DS_ACK;
              n.phase = 6'h00;
            end else begin
              n.st = DS_SKIP;
            end
          end else begin
            n.sda_oe = 1'b1;
            n.st = DS_ACK;
            // phases 0 and 1 are command and count, dropped
            if (r.phase >= 6'h02 && idx <= LAST_IDX) begin
              if (idx >= GRP_BASE && gi < 6'(GRP_N)) begin
                n.gshadow[gi[2:0]] = r.sh;
                n.gmask[gi[2:0]] = 1'b1;
              end else if (idx == IDX_COUNT) begin
                // zero would end every read after byte 0
                if (r.sh != 8'h00) begin
                  n.regs[IDX_COUNT[4:0]] = r.sh;
                end
              end else if (idx != IDX_LATCH && idx != IDX_VENDOR &&
                           idx != IDX_REV) begin
                n.regs[idx[4:0]] = r.sh;
              end
            end
            if (r.phase != 6'h3f) begin
              n.phase = r.phase + 6'h01;
            end
          end
        end
      end
      DS_ACK: begin
        if (fall) begin
          if (r.rd) begin
            n.txb = nb;
            n.sda_oe = ~nb[7];
            n.phase = r.phase + 6'h01;
            n.bitcnt = 4'h0;
            n.st = DS_TX;
          end else begin
            n.sda_oe = 1'b0;
            n.st = DS_RX;
          end
        end
      end
      DS_TX: begin
        if (fall) begin
          if (r.bitcnt == 4'h7) begin
            n.sda_oe = 1'b0;
            n.st = DS_RACK;
          end else begin
            n.bitcnt = r.bitcnt + 4'h1;
            n.txb = {r.txb[6:0], 1'b0};
            n.sda_oe = ~r.txb[6];
          end
        end
      end
      DS_RACK: begin
        if (rise) begin
          n.sh[0] = sda_s;
        end else if (fall) begin
          if (!r.sh[0] && r.phase != 6'h3f) begin
            n.txb = nb;
            n.sda_oe = ~nb[7];
            n.phase = r.phase + 6'h01;
            n.bitcnt = 4'h0;
            n.st = DS_TX;
          end else begin
            n.st = DS_SKIP;
          end
        end
      end
      default: begin
        n.st = DS_IDLE;
        n.sda_oe = 1'b0;
      end
    endcase
    if (start_c) begin
      n.st = DS_ADDR;
      n.bitcnt = 4'h0;
      n.sda_oe = 1'b0;
      n.gmask = '0;
    end else if (stop_c) begin
      // groups commit only as whole sets
      for (int k = 0; k < GRP_N; k++) begin
        if (grp_done(r.gmask, k)) begin
          n.regs[GRP_BASE[4:0] + 5'(k)] = r.gshadow[k];
        end
      end
      n.gmask = '0;
      n.st = DS_IDLE;
      n.sda_oe = 1'b0;
    end
    // wait for the synchroniser to fill before taking the straps
    if (!r.strap_done) begin
      if (r.strap_cnt == 2'h3) begin
        n.latched = sy[4:0];
        n.strap_done = 1'b1;
      end else begin
        n.strap_cnt = r.strap_cnt + 2'h1;
      end
    end
    if (!r.regs[IDX_WDOG[4:0]][WDOG_EN_BIT]) begin
      n.tick = 32'h0;
      n.secs = 8'h00;
      n.fired = 1'b0;
    end else if (wdog_kick || !sy[6] || r.fired) begin
      n.tick = 32'h0;
      n.secs = 8'h00;
    end else if (r.tick == WDOG_TICK_CYCLES - 1) begin
      n.tick = 32'h0;
      if (r.secs + 8'h01 >= r.regs[IDX_WSEC[4:0]]) begin
        n.fired = 1'b1;
      end else begin
        n.secs = r.secs + 8'h01;
      end
    end else begin
      n.tick = r.tick + 32'h1;
    end
    if (r.fired) begin
      n.freq_out = r.regs[IDX_WDOG[4:0]][FS_W-1:0];
    end else if (r.regs[IDX_CFG[4:0]][CFG_HWSEL_BIT]) begin
      n.freq_out = {r.regs[IDX_CFG[4:0]][2], r.regs[IDX_CFG[4:0]][7:4]};
    end else begin
      n.freq_out = r.latched;
    end
    n.usb48 = !sy[5];
    n.mem_en = sy[6] && r.regs[IDX_OUT1[4:0]][MEM_EN_BIT];
    n.oen = sy[6] ? {r.regs[5], r.regs[4], r.regs[3], r.regs[2], r.regs[1]}
                  : '0;
    n.run = sy[6];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.st <= DS_IDLE;
      r.regs <= REG_RST;
      r.scl_q <= 1'b1;
      r.sda_q <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = r.sda_oe;
  assign host_bus_freq_sel = r.freq_out;
  assign selectable_usb_rate_48 = r.usb48;
  assign mem_clk_en = r.mem_en;
  assign output_enable = r.oen;
  assign clocks_run = r.run;
  assign wdog_fired = r.fired;
endmodule

// file: csp_host.sv
// Purpose: bus host end that writes and reads the device bytes
// Assumes: software drives it over ahb-lite, zero wait states
// Notes: one transfer at a time; start ignored while busy
`timescale 1ns/10ps
module csp_host #(
  parameter int QTR_CYCLES = csp_pkg::QTR_CYCLES_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  csp_if.host link
);
  import csp_pkg::*;

  typedef struct packed {
    csp_host_st_t st;
    logic [1:0] q;
    logic [15:0] div;
    logic [3:0] bitn;
    logic [8:0] osh;
    logic [8:0] ish;
    logic rd;
    logic [5:0] byte_no;
    logic [5:0] len;
    logic nack;
    logic [7:0] cnt_byte;
    logic [NUM_BYTES-1:0][7:0] mem;
    logic scl_oe;
    logic sda_oe;
    logic a_valid;
    logic a_wr;
    logic [11:0] a_addr;
    logic [31:0] rdata;
    logic ready;
  } csp_host_s_t;

  csp_host_s_t r;
  csp_host_s_t n;
  logic sda_s;

  csp_sync #(.W(1), .RST(1'b1)) u_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .d(link.sda),
    .q(sda_s)
  );

  always_comb begin
    logic tick;
    logic [9:0] bi;
    logic [5:0] nxt;
    n = r;
    tick = (r.div == 16'(QTR_CYCLES - 1));
    bi = r.a_addr[11:2] - H_BUF[11:2];
    nxt = r.byte_no + 6'h01;
    n.div = (r.st == HS_IDLE || tick) ? 16'h0 : r.div + 16'h1;
    // ahb data phase: write lands one cycle after the address
    if (r.a_valid && r.a_wr) begin
      if (r.a_addr == H_CTRL && hwdata[0] && r.st == HS_IDLE) begin
        n.rd = hwdata[1];
        n.st = HS_START;
        n.q = 2'h0;
        n.nack = 1'b0;
        n.byte_no = 6'h00;
        n.bitn = 4'h0;
        n.osh = {hwdata[1] ? ADDR_RD : ADDR_WR, 1'b1};
      end else if (r.a_addr == H_LEN) begin
        n.len = hwdata[5:0];
      end else if (r.a_addr >= H_BUF && bi < 10'(NUM_BYTES)) begin
        n.mem[bi[4:0]] = hwdata[7:0];
      end
    end
    n.a_valid = hsel && hready && htrans[1];
    n.a_wr = hwrite;
    n.a_addr = {haddr[11:2], 2'b00};
    bi = haddr[11:2] - H_BUF[11:2];
    if (haddr[11:0] == H_STAT) begin
      n.rdata = {16'h0, r.cnt_byte, 6'h0, r.nack, r.st != HS_IDLE};
    end else if (haddr[11:0] == H_LEN) begin
      n.rdata = {26'h0, r.len};
    end else if (haddr[11:0] >= H_BUF && bi < 10'(NUM_BYTES)) begin
      n.rdata = {24'h0, r.mem[bi[4:0]]};
    end else begin
      n.rdata = 32'h0;
    end
    if (tick) begin
      n.q = r.q + 2'h1;
      case (r.st)
        HS_IDLE: begin
        end
        HS_START: begin
          if (r.q == 2'h0) begin
            n.sda_oe = 1'b1;
          end else begin
            n.scl_oe = 1'b1;
            n.q = 2'h0;
            n.st = HS_BIT;
          end
        end
        HS_BIT: begin
          if (r.q == 2'h0) begin
            n.sda_oe = ~r.osh[8];
          end else if (r.q == 2'h1) begin
            n.scl_oe = 1'b0;
          end else if (r.q == 2'h2) begin
            n.ish = {r.ish[7:0], sda_s};
          end else begin
            n.scl_oe = 1'b1;
            n.osh = {r.osh[7:0], 1'b1};
            n.bitn = r.bitn + 4'h1;
            if (r.bitn == 4'h8) begin
              n.bitn = 4'h0;
              n.byte_no = nxt;
              if (!r.rd) begin
                // command and count bytes carry no meaning
                if (r.ish[0] || r.byte_no == r.len + 6'h02) begin
                  n.nack = r.ish[0];
                  n.st = HS_STOP;
                end else if (nxt == 6'h01) begin
                  n.osh = 9'h001;
                end else if (nxt == 6'h02) begin
                  n.osh = {2'b00, r.len, 1'b1};
                end else begin
                  n.osh = {r.mem[5'(nxt - 6'h03)], 1'b1};
                end
              end else begin
                if (r.byte_no == 6'h00 && r.ish[0]) begin
                  n.nack = 1'b1;
                  n.st = HS_STOP;
                end else begin
                  if (r.byte_no == 6'h01) begin
                    n.cnt_byte = r.ish[8:1];
                  end else if (r.byte_no >= 6'h02) begin
                    n.mem[5'(r.byte_no - 6'h02)] = r.ish[8:1];
                  end
                  if (r.byte_no == r.len + 6'h01) begin
                    n.st = HS_STOP;
                  end else begin
                    n.osh = 9'h1fe;
                  end
                end
              end
              if (n.st == HS_STOP) begin
                n.q = 2'h0;
              end
            end
          end
        end
        HS_STOP: begin
          if (r.q == 2'h0) begin
            n.sda_oe = 1'b1;
          end else if (r.q == 2'h1) begin
            n.scl_oe = 1'b0;
          end else if (r.q == 2'h2) begin
            n.sda_oe = 1'b0;
          end else begin
            n.st = HS_IDLE;
          end
        end
        default: begin
          n.st = HS_IDLE;
        end
      endcase
    end
  end

  // quarter period sets the bus rate, at most 100 kbit/s with the default QTR_CYCLES
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.st <= HS_IDLE;
      r.ready <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign link.host_scl_o = 1'b0;
  assign link.host_scl_oe = r.scl_oe;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = r.sda_oe;
  assign hreadyout = r.ready;
  assign hrdata = r.rdata;
  assign hresp = 1'b0;
endmodule

// file: csp_link_asserts.sv
// Purpose: checks on the two-wire link between host and device ends
// Assumes: one clock domain, link seen through resolved wire levels
// Notes: frame position tracked from scl rises since the last start
`timescale 1ns/10ps
module csp_link_asserts #(
  parameter int QTR_CYCLES = 63
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q, sda_q, fst, wr_m, rd_m;
  logic [3:0] cnt;
  logic [7:0] sh;
  logic [11:0] lo_n, hi_n;
  logic rise, fall, strt, stp;
  assign rise = scl && !scl_q;
  assign fall = !scl && scl_q;
  assign strt = scl && scl_q && sda_q && !sda;
  assign stp = scl && scl_q && !sda_q && sda;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      fst <= 1'b0;
      wr_m <= 1'b0;
      rd_m <= 1'b0;
      cnt <= 4'h0;
      sh <= 8'h00;
      lo_n <= 12'h000;
      hi_n <= 12'h000;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      // saturate so idle stretches never wrap
      lo_n <= scl ? 12'h000 : (&lo_n ? lo_n : lo_n + 12'h001);
      hi_n <= !scl ? 12'h000 : (&hi_n ? hi_n : hi_n + 12'h001);
      if (strt || stp) begin
        cnt <= 4'h0;
        fst <= strt;
        wr_m <= 1'b0;
        rd_m <= 1'b0;
      end else if (rise) begin
        cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
        if (cnt < 4'h8) begin
          sh <= {sh[6:0], sda};
        end
        if (cnt == 4'h8 && fst) begin
          fst <= 1'b0;
          wr_m <= (sh == 8'hd2);
          rd_m <= (sh == 8'hd3);
        end
      end
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_addr_ack: assert property (
    rise && cnt == 4'h8 && fst |-> dev_sda_oe == (sh == 8'hd2 || sh == 8'hd3))
    else $error("address acknowledge wrong");
  a_write_ack: assert property (
    rise && cnt == 4'h8 && !fst && wr_m |-> dev_sda_oe)
    else $error("write byte not acknowledged");
  a_read_release: assert property (
    rise && cnt == 4'h8 && !fst && rd_m |-> !dev_sda_oe)
    else $error("device holds sda in host ack bit");
  // checked at scl falls: the host ack bit's own rise has the host pulling sda
  a_host_quiet: assert property (
    rd_m && !fst && cnt != 4'h0 && fall |-> !host_sda_oe)
    else $error("host drives sda during read data");
  a_dev_quiet: assert property (
    wr_m && !fst && cnt < 4'h8 && rise |-> !dev_sda_oe)
    else $error("device drives sda during write data");
  a_dev_edge_safe: assert property (
    $changed(dev_sda_oe) |-> !scl && !$past(scl))
    else $error("device changed sda while scl high");
  a_stop_whole: assert property (stp |-> cnt == 4'h1)
    else $error("stop not after a whole byte");
  a_scl_low_len: assert property (rise |-> lo_n >= QTR_CYCLES)
    else $error("scl low phase too short");
  a_scl_high_len: assert property (fall |-> hi_n >= QTR_CYCLES)
    else $error("scl high phase too short");
endmodule

// file: clockgen_serial_program_port_tb.sv
// Purpose: drives the host end over ahb-lite against the device end
// Assumes: short host quarter period and watchdog tick for run time
// Notes: byte model follows load, ignore and group rules
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
  err_count++; $display("Error %s exp %0h got %0h", nm, e, g); end end
module clockgen_serial_program_port_tb;
  import csp_pkg::*;
  localparam int Q = 8;
  localparam logic [7:0] VEND = 8'h3c; // arbitrary value
  localparam logic [7:0] REV = 8'h81; // arbitrary value
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic hreadyout, hresp, pd_n = 1'b1, usb_n = 1'b1, kick = 1'b0;
  logic usb48, mem_en, run, fired;
  logic [4:0] fs, fs_in, freq;
  logic [39:0] oen;
  logic [7:0] m [0:28];
  logic [7:0] pl [0:28];
  int err_count = 0, n_tests = 0, seed = 32'h842e;
  int nw [4] = '{7, 15, 16, 3};
  logic [7:0] c6 [4] = '{8'h00, 8'h1c, 8'h10, 8'h07};
  csp_if lnk();
  csp_dev #(.WDOG_TICK_CYCLES(10), .VENDOR_BYTE(VEND), .REVISION_BYTE(REV))
    csp_dev_inst (.hclk(hclk), .hresetn(hresetn), .link(lnk.dev),
    .freq_select_in0(fs_in[0]), .freq_select_in1(fs_in[1]),
    .freq_select_in2(fs_in[2]), .freq_select_in3(fs_in[3]),
    .freq_select_in4(fs_in[4]), .power_down_n(pd_n),
    .usb_rate_sel_n(usb_n), .wdog_kick(kick), .host_bus_freq_sel(freq),
    .selectable_usb_rate_48(usb48), .mem_clk_en(mem_en),
    .output_enable(oen), .clocks_run(run), .wdog_fired(fired));
  csp_host #(.QTR_CYCLES(Q)) csp_host_inst (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .link(lnk.host));
  csp_link_asserts #(.QTR_CYCLES(Q)) csp_link_asserts_inst (.hclk(hclk),
    .hresetn(hresetn), .host_scl_o(lnk.host_scl_o),
    .host_scl_oe(lnk.host_scl_oe), .host_sda_o(lnk.host_sda_o),
    .host_sda_oe(lnk.host_sda_oe), .dev_sda_o(lnk.dev_sda_o),
    .dev_sda_oe(lnk.dev_sda_oe), .scl(lnk.scl), .sda(lnk.sda));
  always #20 hclk = ~hclk;
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic xfer(input logic rd, input int n);
    for (int i = 0; i < n && !rd; i++) begin
      bus(1'b1, H_BUF + 12'(4 * i), {24'h0, pl[i]}, q);
    end
    bus(1'b1, H_LEN, 32'(n), q);
    bus(1'b1, H_CTRL, {30'h0, rd, 1'b1}, q);
    // let the start land before polling busy
    repeat (2) @(posedge hclk);
    do bus(1'b0, H_STAT, 32'h0, q); while (q[0] !== 1'b0);
    `CHK("nack", 1'b0, q[1])
    `CHK("resp", 1'b0, hresp)
  endtask
  function automatic void commit(int n);
    for (int i = 0; i < n; i++) begin
      if (!(i inside {7, 11, 12}) && !(i == 6 && pl[i] == 8'h00) &&
          !(i >= 14 && i <= 20 && n < (i < 16 ? 16 : (i < 18 ? 18 : 21))))
        m[i] = pl[i];
    end
  endfunction
  function automatic logic [7:0] exp_b(int i);
    return i == 7 ? {3'b000, ~fs} : (i == 11 ? VEND : (i == 12 ? REV : m[i]));
  endfunction
  task automatic rd_chk;
    int n;
    n = int'(m[6]) + 1;
    xfer(1'b1, n);
    `CHK("count", m[6], q[15:8])
    for (int i = 0; i < n; i++) begin
      bus(1'b0, H_BUF + 12'(4 * i), 32'h0, q);
      `CHK("read byte", exp_b(i), q[7:0])
    end
  endtask
  task automatic fill(input logic [7:0] b6);
    for (int i = 0; i < 29; i++) begin
      pl[i] = m[i] ^ 8'($random(seed));
    end
    pl[0][3] = 1'b0;
    pl[6] = b6;
    pl[8] = 8'h00;
    pl[13] = 8'h00;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    // generous span over the expected run length
    #(CLK_PERIOD_NS * 80000);
    err_count++;
    close_out();
  end
  initial begin
    fs = 5'($random(seed));
    fs_in = fs;
    for (int i = 0; i < 29; i++) m[i] = REG_RST[8 * i +: 8];
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
    `CHK("straps", fs, freq)
    `CHK("usb default", 1'b0, usb48)
    fs_in <= ~fs;
    rd_chk();
    $display("test default read done");
    for (int k = 0; k < 4; k++) begin
      fill(k == 3 ? 8'(7 + {$random(seed)} % 22) : c6[k]);
      xfer(1'b0, nw[k]);
      commit(nw[k]);
      `CHK("mem clock", m[1][0], mem_en)
      `CHK("freq", fs, freq)
      rd_chk();
      $display("test transfer %0d done", k);
    end
    for (int k = 0; k < 2; k++) begin
      usb_n <= k[0];
      repeat (6) @(posedge hclk);
      `CHK("usb rate", ~usb_n, usb48)
    end
    pd_n <= 1'b0;
    repeat (8) @(posedge hclk);
    `CHK("run", 1'b0, run)
    `CHK("enables", 40'h0, oen)
    `CHK("mem off", 1'b0, mem_en)
    pd_n <= 1'b1;
    repeat (8) @(posedge hclk);
    `CHK("run again", 1'b1, run)
    `CHK("mem again", m[1][0], mem_en)
    $display("test power down done");
    // kick held through the write keeps a stale count from firing early
    kick <= 1'b1;
    fill(m[6]);
    pl[8] = {3'b001, ~fs};
    pl[9] = 8'h02;
    xfer(1'b0, 10);
    commit(10);
    repeat (40) @(posedge hclk);
    `CHK("kicked", 1'b0, fired)
    kick <= 1'b0;
    for (int i = 0; i < 400 && fired !== 1'b1; i++) @(posedge hclk);
    repeat (2) @(posedge hclk);
    `CHK("fired", 1'b1, fired)
    `CHK("safe freq", ~fs, freq)
    $display("test watchdog done");
    fill(m[6]);
    pl[0][3] = 1'b1;
    xfer(1'b0, 9);
    commit(9);
    repeat (4) @(posedge hclk);
    `CHK("fired cleared", 1'b0, fired)
    `CHK("soft freq", {m[0][2], m[0][7:4]}, freq)
    $display("test soft select done");
    close_out();
  end
endmodule
